/* File: lamp_pkg.sv */
package lamp_pkg;

  // Register byte offsets on the APB port.
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] DUR_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;

  // Control register field positions.
  localparam int MIXER_SEL_BIT = 28;
  localparam int ENABLE_BIT = 27;
  localparam int PROTECT_BIT = 26;
  localparam int SRC_SEL_BIT = 25;
  localparam int SOFT_SYNC_BIT = 24;
  localparam int PRESCALE_LSB = 0;

  // Duration register field positions.
  localparam int FLASH_LSB = 16;
  localparam int PAUSE_LSB = 8;
  localparam int IGNITE_LSB = 0;

  // Status register field positions.
  localparam int STATUS_PHASE_LSB = 0;
  localparam int STATUS_PINS_LSB = 4;

  // Reset values.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] DUR_RESET = 32'h0000_0000;

  // Phase lengths in base periods: start-up is fixed, ionisation, pause and flash are macro
  // cycles of four base periods times the programmed value; idle and off have none.
  localparam logic [17:0] START_TICKS = 18'h00008;
  localparam int MACRO_SHIFT = 2;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_OFF = 3'b001,
    PH_START = 3'b010,
    PH_ION = 3'b011,
    PH_PAUSE = 3'b100,
    PH_FLASH = 3'b101
  } phase_t;

  typedef struct packed {
    logic mixerSel;
    logic enable;
    logic protect;
    logic srcSel;
    logic softSync;
    logic [7:0] prescale;
  } lamp_ctrl_t;

  typedef struct packed {
    logic [15:0] flash;
    logic [7:0] pause;
    logic [7:0] ignite;
  } durations_t;

  typedef struct packed {
    logic gateDriveA;
    logic gateDriveB;
    logic ignitionOut;
    logic lampOffNPwm;
  } lamp_pins_t;

  localparam lamp_pins_t PINS_INACTIVE = 4'b0001;

endpackage

/* File: lamp_prescaler.sv */
`timescale 1ns/1ps
module lamp_prescaler
  import lamp_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic restart, // Realign the base period to this cycle.
  input wire logic [7:0] scale, // Clocks per base period.
  output logic tick // One-cycle pulse at each base period end.
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] last;

  // A scale of zero would give no base period at all, so it acts as one.
  always_comb begin
    last = (scale == 8'h00) ? 8'h00 : scale - 8'h01;
    tick = (cnt_r >= last) && !restart;
    if (restart || tick) begin
      cnt_nxt = 8'h00;
    end else begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

/* File: lamp_gate_toggle.sv */
`timescale 1ns/1ps
module lamp_gate_toggle
  import lamp_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic active, // A pulsed phase is running.
  input wire logic tick, // Base period pulse.
  output logic phase // Low selects gate A, high selects gate B.
);

  logic phase_r;
  logic phase_nxt;

  // Each base period hands the drive to the other gate; outside a pulsed
  // phase the toggle returns to gate A so every burst starts the same way.
  always_comb begin
    if (!active) begin
      phase_nxt = 1'b0;
    end else if (tick) begin
      phase_nxt = !phase_r;
    end else begin
      phase_nxt = phase_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign phase = phase_r;

endmodule

/* File: cold_cathode_lamp_driver.sv */
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Cycle runs start-up, ionisation, pause, flash, then off until sync.
// - A rising edge of the chosen sync starts a cycle, ending off phase.
// - Base period is clock period times the programmed prescaler value.
// - Start-up phase always lasts eight base periods.
// - Ionisation, pause, flash last four base periods times their values.
// - Off phase fills the remaining time up to the next sync edge.
// - A sync edge during flash is ignored; lamp stays off one period.
// - Gate outputs pulse only in ionisation and flash, else low.
// - Ignition output is high in start-up and ionisation only.
// - Lamp-off output is low during phases, high in idle and off phases and while disabled.
// - A gate pulse still high at a phase end is cut short.
// - Graphics frame sync is accepted as a synchronisation input.
// - Software writing the sync flag produces a sync event.
// - Sync mixer output is selectable as a third sync source.
// - Host configures over the register port; then cycles run alone.
// - With enable clear, gates and ignition low, lamp-off high.
// - With protect set, duration writes store but timing keeps old values.
// - Source select 0 uses frame sync, 1 uses the software flag.
// - Mixer select overrides source select when set.
module cold_cathode_lamp_driver
  import lamp_pkg::*;
(
  input wire logic clk, // System clock, 50 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [11:0] paddr, // APB address.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write direction.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic frameSync, // Graphics frame sync, same clock.
  input wire logic mixerSync, // Sync mixer output, same clock.
  output logic gateDriveA, // First FET gate.
  output logic gateDriveB, // Second FET gate.
  output logic ignitionOut, // Ignition control, high active.
  output logic lampOffNPwm // Lamp off, low while the lamp runs.
);

  lamp_ctrl_t ctrl_r;
  lamp_ctrl_t ctrl_nxt;
  durations_t dur_r;
  durations_t dur_nxt;
  durations_t durEff_r;
  durations_t durEff_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  phase_t state_r;
  phase_t state_nxt;
  logic [17:0] cnt_r;
  logic [17:0] cnt_nxt;
  lamp_pins_t pins_r;
  lamp_pins_t pins_nxt;
  logic syncLevel;
  logic syncPrev_r;
  logic syncEdge;
  logic tick;
  logic gatePhase;
  logic pulsing;
  logic [17:0] target;
  logic phaseDone;
  logic mapped;
  logic setupRd;
  logic accessWr;

  // Phase length in base periods for the programmed durations.
  function automatic logic [17:0] phaseLen(input phase_t ph,
                                           input durations_t d);
    logic [17:0] len;
    len = 18'h00000;
    unique case (ph)
      PH_START: len = START_TICKS;
      PH_ION: len = {8'h00, d.ignite, 2'b00};
      PH_PAUSE: len = {8'h00, d.pause, 2'b00};
      PH_FLASH: len = {d.flash, 2'b00};
      PH_IDLE, PH_OFF: len = 18'h00000;
    endcase
    return len;
  endfunction

  // True for the phases in which the gates are pulsed.
  function automatic logic isPulsed(input phase_t ph);
    return (ph == PH_ION) || (ph == PH_FLASH);
  endfunction

  // The APB slave answers in the access cycle with no wait states; read
  // data is prepared in the setup cycle so that it leaves a flip-flop.
  assign mapped = (paddr == CTRL_OFFSET) || (paddr == DUR_OFFSET) ||
                  (paddr == STATUS_OFFSET);
  assign setupRd = psel && !penable && !pwrite;
  assign accessWr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // Register writes; the host sets everything here and then leaves the
  // block to run on its own.
  always_comb begin
    ctrl_nxt = ctrl_r;
    dur_nxt = dur_r;
    if (accessWr && paddr == CTRL_OFFSET) begin
      ctrl_nxt.mixerSel = pwdata[MIXER_SEL_BIT];
      ctrl_nxt.enable = pwdata[ENABLE_BIT];
      ctrl_nxt.protect = pwdata[PROTECT_BIT];
      ctrl_nxt.srcSel = pwdata[SRC_SEL_BIT];
      ctrl_nxt.softSync = pwdata[SOFT_SYNC_BIT];
      ctrl_nxt.prescale = pwdata[PRESCALE_LSB +: 8];
    end
    if (accessWr && paddr == DUR_OFFSET) begin
      dur_nxt.flash = pwdata[FLASH_LSB +: 16];
      dur_nxt.pause = pwdata[PAUSE_LSB +: 8];
      dur_nxt.ignite = pwdata[IGNITE_LSB +: 8];
    end
    // Timing follows the stored durations only while unprotected, so a
    // half-written set never reaches the lamp.
    durEff_nxt = ctrl_r.protect ? durEff_r : dur_r;
  end

  // Read data mux; reserved bits read as zero.
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (setupRd) begin
      if (paddr == CTRL_OFFSET) begin
        prdata_nxt[MIXER_SEL_BIT] = ctrl_r.mixerSel;
        prdata_nxt[ENABLE_BIT] = ctrl_r.enable;
        prdata_nxt[PROTECT_BIT] = ctrl_r.protect;
        prdata_nxt[SRC_SEL_BIT] = ctrl_r.srcSel;
        prdata_nxt[SOFT_SYNC_BIT] = ctrl_r.softSync;
        prdata_nxt[PRESCALE_LSB +: 8] = ctrl_r.prescale;
      end else if (paddr == DUR_OFFSET) begin
        prdata_nxt = dur_r;
      end else if (paddr == STATUS_OFFSET) begin
        prdata_nxt[STATUS_PHASE_LSB +: 3] = state_r;
        prdata_nxt[STATUS_PINS_LSB +: 4] = pins_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET[12:0];
      dur_r <= DUR_RESET;
      durEff_r <= DUR_RESET;
      prdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      dur_r <= dur_nxt;
      durEff_r <= durEff_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Source selection: the mixer wins, then the software flag, else the
  // frame sync. A select change may itself look like an edge.
  always_comb begin
    if (ctrl_r.mixerSel) begin
      syncLevel = mixerSync;
    end else if (ctrl_r.srcSel) begin
      syncLevel = ctrl_r.softSync;
    end else begin
      syncLevel = frameSync;
    end
    syncEdge = syncLevel && !syncPrev_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      syncPrev_r <= 1'b0;
    end else begin
      syncPrev_r <= syncLevel;
    end
  end

  // The base period restarts with each cycle so start-up is exact.
  lamp_prescaler prescaler (
    .clk(clk),
    .rst(rst),
    .restart(state_r == PH_OFF && syncEdge),
    .scale(ctrl_r.prescale),
    .tick(tick)
  );

  assign pulsing = isPulsed(state_r);

  lamp_gate_toggle toggle (
    .clk(clk),
    .rst(rst),
    .active(pulsing),
    .tick(tick),
    .phase(gatePhase)
  );

  // Phase sequencer. A zero-length phase is passed straight through.
  always_comb begin
    target = phaseLen(state_r, durEff_r);
    phaseDone = (target == 18'h00000) ||
                (tick && cnt_r == target - 18'h00001);
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (!ctrl_r.enable) begin
      state_nxt = PH_IDLE;
      cnt_nxt = 18'h00000;
    end else begin
      unique case (state_r)
        PH_IDLE: state_nxt = PH_OFF;
        PH_OFF: begin
          if (syncEdge) begin
            state_nxt = PH_START;
            cnt_nxt = 18'h00000;
          end
        end
        PH_START, PH_ION, PH_PAUSE, PH_FLASH: begin
          // Sync edges are simply not looked at here; one arriving in
          // flash is lost and the lamp skips that period.
          if (phaseDone) begin
            cnt_nxt = 18'h00000;
            unique case (state_r)
              PH_START: state_nxt = PH_ION;
              PH_ION: state_nxt = PH_PAUSE;
              PH_PAUSE: state_nxt = PH_FLASH;
              default: state_nxt = PH_OFF;
            endcase
          end else if (tick) begin
            cnt_nxt = cnt_r + 18'h00001;
          end
        end
        default: state_nxt = PH_IDLE;
      endcase
    end
  end

  // Pins follow the phase one clock later; leaving a pulsed phase drops
  // the gate on the boundary even mid-pulse.
  always_comb begin
    pins_nxt = PINS_INACTIVE;
    if (ctrl_r.enable) begin
      pins_nxt.gateDriveA = pulsing && !gatePhase;
      pins_nxt.gateDriveB = pulsing && gatePhase;
      pins_nxt.ignitionOut = (state_r == PH_START) ||
                             (state_r == PH_ION);
      pins_nxt.lampOffNPwm = (state_r == PH_OFF) ||
                             (state_r == PH_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= PH_IDLE;
      cnt_r <= 18'h00000;
      pins_r <= PINS_INACTIVE;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign gateDriveA = pins_r.gateDriveA;
  assign gateDriveB = pins_r.gateDriveB;
  assign ignitionOut = pins_r.ignitionOut;
  assign lampOffNPwm = pins_r.lampOffNPwm;

  // Checks on the sequencer and the pins.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sync_start_a: assert property (
    ctrl_r.enable && state_r == PH_OFF && syncEdge |=> state_r == PH_START)
    else $error("sync edge in off phase did not start a cycle");

  flash_ignore_a: assert property (
    ctrl_r.enable && state_r == PH_FLASH && syncEdge && !phaseDone
    |=> state_r == PH_FLASH)
    else $error("sync edge disturbed a running flash phase");

  gate_excl_a: assert property (
    !(gateDriveA && gateDriveB))
    else $error("both gate outputs high");

  gate_quiet_a: assert property (
    !isPulsed(state_r) |=> !gateDriveA && !gateDriveB)
    else $error("gate pulse outside a pulsed phase");

  gate_cut_a: assert property (
    isPulsed(state_r) && !isPulsed(state_nxt)
    |=> ##1 !gateDriveA && !gateDriveB)
    else $error("gate pulse ran past the phase end");

  ignite_level_a: assert property (
    ctrl_r.enable && state_r == PH_PAUSE |=> !ignitionOut)
    else $error("ignition high during pause");

  off_level_a: assert property (
    ctrl_r.enable && state_r == PH_FLASH |=> !lampOffNPwm)
    else $error("lamp off output high during flash");

  disable_pins_a: assert property (
    !ctrl_r.enable |=> !gateDriveA && !gateDriveB && !ignitionOut &&
                       lampOffNPwm)
    else $error("pins active while driver disabled");

  start_len_a: assert property (
    state_r == PH_START && phaseDone |-> tick && cnt_r == 18'h00007)
    else $error("start-up phase not eight base periods");

  protect_hold_a: assert property (
    ctrl_r.protect && $past(ctrl_r.protect) |-> $stable(durEff_r))
    else $error("protected durations changed");

  // A prescale write landing on a tick legally shortens the next period.
  prescale_two_a: assert property (
    tick && ctrl_r.prescale == 8'h02 && !syncEdge &&
    $stable(ctrl_r.prescale) |=> !tick || $changed(ctrl_r.prescale))
    else $error("base period shorter than two clocks");

  edge_single_a: assert property (
    syncEdge |=> !syncEdge)
    else $error("held sync level gave repeated events");

  full_cycle_c: cover property (
    state_r == PH_FLASH ##1 state_r == PH_OFF);
  flash_skip_c: cover property (
    state_r == PH_FLASH && syncEdge && !phaseDone);
  protect_c: cover property (
    ctrl_r.protect && accessWr && paddr == DUR_OFFSET);

endmodule

/* File: lamp_supply_model.sv */
`timescale 1ns/1ps
module lamp_supply_model (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic gateDriveA, // First FET gate.
  input wire logic gateDriveB, // Second FET gate.
  input wire logic ignitionOut, // Ignition control.
  input wire logic lampOffNPwm, // Lamp off, high while dark.
  output logic [15:0] pulsesA, // Rising edges seen on gate A.
  output logic [15:0] pulsesB, // Rising edges seen on gate B.
  output logic [15:0] faults // Cycles of drive that would harm the supply.
);
  logic prevA_r;
  logic prevB_r;

  // The transformer primary shorts if both FETs conduct, and the supply must
  // stay quiet while the lamp is off, so both cases are counted as faults.
  always_ff @(posedge clk) begin
    if (rst) begin
      prevA_r <= 1'b0;
      prevB_r <= 1'b0;
      pulsesA <= 16'h0000;
      pulsesB <= 16'h0000;
      faults <= 16'h0000;
    end else begin
      prevA_r <= gateDriveA;
      prevB_r <= gateDriveB;
      if (gateDriveA && !prevA_r) begin
        pulsesA <= pulsesA + 16'h0001;
      end
      if (gateDriveB && !prevB_r) begin
        pulsesB <= pulsesB + 16'h0001;
      end
      if (gateDriveA && gateDriveB) begin
        faults <= faults + 16'h0001;
      end else if (lampOffNPwm &&
                   (gateDriveA || gateDriveB || ignitionOut)) begin
        faults <= faults + 16'h0001;
      end
    end
  end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  import lamp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic frameSync = 1'b0;
  logic mixerSync = 1'b0;
  logic gateDriveA, gateDriveB, ignitionOut, lampOffNPwm;
  logic [15:0] pulsesA, pulsesB, faults;
  logic [31:0] rd;
  logic err;
  int err_total = 0;
  int n_compared = 0;

  cold_cathode_lamp_driver cold_cathode_lamp_driver_inst (.clk(clk),
    .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frameSync(frameSync), .mixerSync(mixerSync),
    .gateDriveA(gateDriveA), .gateDriveB(gateDriveB),
    .ignitionOut(ignitionOut), .lampOffNPwm(lampOffNPwm));

  lamp_supply_model lamp_supply_model_inst (.clk(clk), .rst(rst),
    .gateDriveA(gateDriveA), .gateDriveB(gateDriveB),
    .ignitionOut(ignitionOut), .lampOffNPwm(lampOffNPwm),
    .pulsesA(pulsesA), .pulsesB(pulsesB), .faults(faults));

  // Clock at 50 MHz.
  always #10 clk = ~clk;

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; always starts on a fresh edge so signals move only
  // just after rising edges, and waits for pready without assuming latency.
  // Only the watchdog ends a wait that never sees pready.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic mixer);
    @(posedge clk);
    if (mixer) mixerSync <= 1'b1;
    else frameSync <= 1'b1;
    @(posedge clk);
    mixerSync <= 1'b0;
    frameSync <= 1'b0;
  endtask

  // Times one lamp cycle in clocks and counts the gate pulses it produced.
  task automatic measure(input int expOn, input int expIgn, input int expG);
    int on, ign, w;
    logic [15:0] a0, b0;
    on = 0;
    ign = 0;
    w = 0;
    a0 = pulsesA;
    b0 = pulsesB;
    while (lampOffNPwm === 1'b1 && w < 200) begin
      @(negedge clk);
      w++;
    end
    while (lampOffNPwm === 1'b0 && on < 5000) begin
      on++;
      if (ignitionOut === 1'b1) ign++;
      @(negedge clk);
    end
    repeat (2) @(negedge clk);
    check("lamp on time", on, expOn);
    check("ignition time", ign, expIgn);
    check("gate A pulses", pulsesA - a0, expG);
    check("gate B pulses", pulsesB - b0, expG);
    check("supply faults", faults, 32'h0);
  endtask

  // The lamp must stay dark for n clocks.
  task automatic quiet(input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(negedge clk);
      if (lampOffNPwm !== 1'b1) bad++;
    end
    check("dark clocks", bad, 0);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog sized well above the several hundred clocks the tests need.
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("MISMATCH watchdog expected done seen hang");
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    check("pins after reset", {gateDriveA, gateDriveB, ignitionOut,
          lampOffNPwm}, PINS_INACTIVE);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    check("ctrl reset", rd, CTRL_RESET);
    apb(1'b0, DUR_OFFSET, 32'h0);
    check("dur reset", rd, DUR_RESET);
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    check("unmapped error", err, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    check("unmapped read", rd, 32'h0);
    $display("test reset done");

    apb(1'b1, DUR_OFFSET, 32'h0002_0101);
    apb(1'b1, CTRL_OFFSET, 32'h0800_0002);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    check("ctrl readback", rd, 32'h0800_0002);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check("status off", rd, 32'h0000_0011);
    pulse(1'b0);
    measure(48, 24, 6);
    $display("test frame sync done");

    apb(1'b1, CTRL_OFFSET, 32'h0c00_0002);
    apb(1'b1, DUR_OFFSET, 32'h0001_0101);
    apb(1'b0, DUR_OFFSET, 32'h0);
    check("protected write stored", rd, 32'h0001_0101);
    pulse(1'b0);
    measure(48, 24, 6);
    apb(1'b1, CTRL_OFFSET, 32'h0800_0002);
    pulse(1'b0);
    measure(40, 24, 4);
    $display("test protect done");

    apb(1'b1, CTRL_OFFSET, 32'h0a00_0002);
    pulse(1'b0);
    quiet(40);
    apb(1'b1, CTRL_OFFSET, 32'h0b00_0002);
    measure(40, 24, 4);
    apb(1'b1, CTRL_OFFSET, 32'h0b00_0002);
    quiet(40);
    apb(1'b1, CTRL_OFFSET, 32'h0a00_0002);
    $display("test soft sync done");

    apb(1'b1, CTRL_OFFSET, 32'h1800_0002);
    pulse(1'b0);
    quiet(40);
    pulse(1'b1);
    measure(40, 24, 4);
    $display("test mixer sync done");

    apb(1'b1, CTRL_OFFSET, 32'h0800_0001);
    apb(1'b1, DUR_OFFSET, 32'h0010_0101);
    pulse(1'b0);
    fork
      measure(80, 12, 34);
      begin
        repeat (45) @(posedge clk);
        frameSync <= 1'b1;
        @(posedge clk);
        frameSync <= 1'b0;
      end
    join
    quiet(60);
    $display("test overrun done");

    pulse(1'b0);
    repeat (10) @(posedge clk);
    apb(1'b1, CTRL_OFFSET, 32'h0000_0001);
    repeat (3) @(posedge clk);
    check("pins disabled", {gateDriveA, gateDriveB, ignitionOut,
          lampOffNPwm}, PINS_INACTIVE);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check("status idle", rd, 32'h0000_0010);
    pulse(1'b0);
    quiet(40);
    check("supply faults", faults, 32'h0);
    $display("test disable done");
    stop_test();
  end
endmodule
